// file: clr_consts.vh
// constants for the control line loopback router and its register slave
// Behaviour
// - terminal role, loopback: logic inputs a and b return to their own logic outputs; logic output c also takes input b.
// - terminal role, normal: logic inputs drive the line, line receivers feed logic outputs.
// - equipment role, loopback: line a and b receivers return to their own line outputs, line c takes b; logic a returns, input c feeds output b.
// - equipment role, normal: logic inputs drive the line, receivers feed logic outputs.
// - unused line output in the active role may stay undriven or take any value.
// - role 1 is equipment, 0 terminal; loopback pin low enables loopback.
`ifndef CLR_CONSTS_VH
`define CLR_CONSTS_VH

// avalon byte addresses, one aligned word each
`define CLR_ADDR_W 4
`define CLR_OFS_STATUS 4'h0
`define CLR_OFS_CTRL 4'h4
`define CLR_OFS_CHANGES 4'h8

// pin meanings
`define CLR_ROLE_EQUIP 1'b1
`define CLR_ROLE_TERM 1'b0
`define CLR_LOOP_ON 1'b0

// status fields
`define CLR_ST_ROLE 0
`define CLR_ST_LOOP 1
`define CLR_ST_ECHO 2
`define CLR_ST_CLKCNT 3
`define CLR_ST_CLK_INVERT_N 4
`define CLR_ST_DATA_INVERT_N 5
`define CLR_ST_OSC 6
`define CLR_ST_SCEN_LO 8
`define CLR_ST_SCEN_HI 9

// control fields and reset
`define CLR_CTRL_PARK 0
`define CLR_CTRL_DRIVE_UNUSED 1
`define CLR_CTRL_RST 2'h0
`define CLR_CTRL_W 2

// synchroniser and counter widths
`define CLR_NPIN 7
`define CLR_CNT_W 16
`define CLR_CNT_ONE 16'h0001

`endif

// file: clr_route.v
// combinational router between the logic side and the line side
`timescale 1ns/1ps
`include "clr_consts.vh"
module clr_route (
  input wire role_sel,
  input wire loop_n,
  input wire park_lvl,
  input wire drive_unused,
  input wire ctl_a_din,
  input wire ctl_b_din,
  input wire ctl_c_din,
  input wire ctl_a_line_rx,
  input wire ctl_b_line_rx,
  input wire ctl_c_line_i,
  input wire ctl_d_line_i,
  output reg ctl_a_dout,
  output reg ctl_b_dout,
  output reg ctl_c_dout,
  output reg ctl_a_line_tx,
  output reg ctl_b_line_tx,
  output reg ctl_c_line_o,
  output reg ctl_c_line_oe_n,
  output reg ctl_d_line_o,
  output reg ctl_d_line_oe_n
);
  wire equip;
  wire loop_on;

  assign equip = (role_sel == `CLR_ROLE_EQUIP);
  assign loop_on = (loop_n == `CLR_LOOP_ON);

  // pure select logic: a pin change redirects every path at once
  always @*
  begin
    ctl_a_dout = loop_on ? ctl_a_din : ctl_a_line_rx;
    ctl_a_line_tx = loop_on ? ctl_a_line_rx : ctl_a_din;
    ctl_b_dout = ctl_b_line_rx;
    ctl_b_line_tx = ctl_b_din;
    ctl_c_dout = ctl_c_line_i;
    ctl_c_line_o = park_lvl;
    ctl_c_line_oe_n = 1'b1;
    ctl_d_line_o = park_lvl;
    ctl_d_line_oe_n = 1'b1;
    if (equip)
    begin
      // line c is driven, line d is received
      ctl_c_dout = ctl_d_line_i;
      ctl_c_line_oe_n = 1'b0;
      if (loop_on)
      begin
        ctl_b_dout = ctl_c_din;
        ctl_b_line_tx = ctl_b_line_rx;
        ctl_c_line_o = ctl_b_line_rx;
      end
      else
      begin
        ctl_c_line_o = ctl_c_din;
      end
      // unused line d may be parked when software asks
      ctl_d_line_oe_n = ~drive_unused;
    end
    else
    begin
      // line d is driven, line c is received
      ctl_d_line_o = ctl_c_din;
      ctl_d_line_oe_n = 1'b0;
      if (loop_on)
      begin
        ctl_b_dout = ctl_b_din;
        ctl_c_dout = ctl_b_din;
        ctl_b_line_tx = ctl_c_line_i;
      end
      else
      begin
        ctl_c_dout = ctl_c_line_i;
      end
      // in loopback line c is an input; only normal mode may park it
      ctl_c_line_oe_n = loop_on ? 1'b1 : ~drive_unused;
    end
  end
endmodule

// file: clr_top.v
// control line router top: pin routing plus an avalon status and control slave
`timescale 1ns/1ps
`include "clr_consts.vh"
module clr_top (
  input wire mclk,
  input wire rst,
  input wire role_sel,
  input wire loop_n,
  input wire echo_clk_n,
  input wire clk_count_sel,
  input wire clk_invert_n,
  input wire data_invert_n,
  input wire osc_enable_n,
  input wire ctl_a_din,
  input wire ctl_b_din,
  input wire ctl_c_din,
  input wire ctl_a_line_rx,
  input wire ctl_b_line_rx,
  input wire ctl_c_line_i,
  input wire ctl_d_line_i,
  output wire ctl_a_dout,
  output wire ctl_b_dout,
  output wire ctl_c_dout,
  output wire ctl_a_line_tx,
  output wire ctl_b_line_tx,
  output wire ctl_c_line_o,
  output wire ctl_c_line_oe_n,
  output wire ctl_d_line_o,
  output wire ctl_d_line_oe_n,
  input wire [`CLR_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest
);
  // static strap pins, sampled only for status; routing never waits on them
  wire [`CLR_NPIN-1:0] pin_raw;
  reg [`CLR_NPIN-1:0] pin_s1_q;
  reg [`CLR_NPIN-1:0] pin_s2_q;
  reg [`CLR_NPIN-1:0] pin_s3_q;
  reg [`CLR_NPIN-1:0] pin_stable_q;
  reg [`CLR_CNT_W-1:0] changes_q;
  reg [`CLR_CTRL_W-1:0] ctrl_q;
  reg [31:0] rdata_q;
  reg wait_q;
  reg ack_q;
  reg [31:0] rdata_d;
  wire [`CLR_NPIN-1:0] pin_agree;
  wire pin_changed;
  wire req;

  assign pin_raw = {osc_enable_n, data_invert_n, clk_invert_n, clk_count_sel,
                    echo_clk_n, loop_n, role_sel};

  // three-stage sampler per pin; a level counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < `CLR_NPIN; gi = gi + 1)
    begin : g_pin
      assign pin_agree[gi] = (pin_s2_q[gi] == pin_s3_q[gi]);
      always @(posedge mclk)
      begin
        if (rst)
        begin
          pin_s1_q[gi] <= 1'b0;
          pin_s2_q[gi] <= 1'b0;
          pin_s3_q[gi] <= 1'b0;
        end
        else
        begin
          pin_s1_q[gi] <= pin_raw[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
          pin_s3_q[gi] <= pin_s2_q[gi];
        end
      end
    end
  endgenerate

  // settled pin view; host changes of any of the seven strap pins are counted for software
  assign pin_changed = |(pin_agree & (pin_s3_q ^ pin_stable_q));
  always @(posedge mclk)
  begin
    if (rst)
    begin
      pin_stable_q <= {`CLR_NPIN{1'b0}};
      changes_q <= {`CLR_CNT_W{1'b0}};
    end
    else
    begin
      pin_stable_q <= (pin_agree & pin_s3_q) | (~pin_agree & pin_stable_q);
      // saturate rather than wrap so a stuck pin is not hidden
      if (pin_changed && (changes_q != {`CLR_CNT_W{1'b1}}))
      begin
        changes_q <= changes_q + `CLR_CNT_ONE;
      end
    end
  end

  // the router itself; its outputs are combinational on purpose
  clr_route u_route (
    .role_sel(role_sel),
    .loop_n(loop_n),
    .park_lvl(ctrl_q[`CLR_CTRL_PARK]),
    .drive_unused(ctrl_q[`CLR_CTRL_DRIVE_UNUSED]),
    .ctl_a_din(ctl_a_din),
    .ctl_b_din(ctl_b_din),
    .ctl_c_din(ctl_c_din),
    .ctl_a_line_rx(ctl_a_line_rx),
    .ctl_b_line_rx(ctl_b_line_rx),
    .ctl_c_line_i(ctl_c_line_i),
    .ctl_d_line_i(ctl_d_line_i),
    .ctl_a_dout(ctl_a_dout),
    .ctl_b_dout(ctl_b_dout),
    .ctl_c_dout(ctl_c_dout),
    .ctl_a_line_tx(ctl_a_line_tx),
    .ctl_b_line_tx(ctl_b_line_tx),
    .ctl_c_line_o(ctl_c_line_o),
    .ctl_c_line_oe_n(ctl_c_line_oe_n),
    .ctl_d_line_o(ctl_d_line_o),
    .ctl_d_line_oe_n(ctl_d_line_oe_n)
  );

  // read mux; unmapped addresses read zero
  always @*
  begin
    rdata_d = 32'h00000000;
    case (avs_address)
      `CLR_OFS_STATUS:
      begin
        rdata_d[`CLR_NPIN-1:0] = pin_stable_q;
        rdata_d[`CLR_ST_SCEN_LO] = pin_stable_q[`CLR_ST_LOOP];
        rdata_d[`CLR_ST_SCEN_HI] = pin_stable_q[`CLR_ST_ROLE];
      end
      `CLR_OFS_CTRL:
      begin
        rdata_d[`CLR_CTRL_W-1:0] = ctrl_q;
      end
      `CLR_OFS_CHANGES:
      begin
        rdata_d[`CLR_CNT_W-1:0] = changes_q;
      end
      default:
      begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  // one wait cycle per access: waitrequest drops in the second cycle of a request;
  // a write lands only at the edge where the master sees waitrequest low
  assign req = avs_read | avs_write;
  always @(posedge mclk)
  begin
    if (rst)
    begin
      wait_q <= 1'b1;
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
      ctrl_q <= `CLR_CTRL_RST;
    end
    else
    begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
      if (req && !ack_q && wait_q)
      begin
        // accept: answer stands for exactly one edge
        wait_q <= 1'b0;
        ack_q <= 1'b1;
        rdata_q <= avs_read ? rdata_d : 32'h00000000;
      end
      // completing edge: the master still holds address and data here
      if (ack_q && avs_write && (avs_address == `CLR_OFS_CTRL) && avs_byteenable[0])
      begin
        ctrl_q <= avs_writedata[`CLR_CTRL_W-1:0];
      end
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
endmodule

// file: clr_checker.sv
// assertions on the router top ports, bound into the top
`timescale 1ns/1ps
module clr_checker (
  input wire mclk,
  input wire rst,
  input wire role_sel,
  input wire loop_n,
  input wire ctl_a_din,
  input wire ctl_b_din,
  input wire ctl_c_din,
  input wire ctl_a_line_rx,
  input wire ctl_b_line_rx,
  input wire ctl_c_line_i,
  input wire ctl_d_line_i,
  input wire ctl_a_dout,
  input wire ctl_b_dout,
  input wire ctl_c_dout,
  input wire ctl_a_line_tx,
  input wire ctl_b_line_tx,
  input wire ctl_c_line_o,
  input wire ctl_c_line_oe_n,
  input wire ctl_d_line_o,
  input wire ctl_d_line_oe_n
);
  // one clock domain, so clocking and reset are given once
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_a_loop: assert property (!loop_n |-> ctl_a_dout == ctl_a_din &&
    ctl_a_line_tx == ctl_a_line_rx) else $error("channel a loopback wrong");
  a_a_norm: assert property (loop_n |-> ctl_a_dout == ctl_a_line_rx &&
    ctl_a_line_tx == ctl_a_din) else $error("channel a normal path wrong");
  a_b_norm: assert property (loop_n |-> ctl_b_dout == ctl_b_line_rx &&
    ctl_b_line_tx == ctl_b_din) else $error("channel b normal path wrong");
  a_term_loop: assert property (!role_sel && !loop_n |-> ctl_b_dout == ctl_b_din &&
    ctl_c_dout == ctl_b_din && ctl_b_line_tx == ctl_c_line_i) else $error("terminal loop wrong");
  a_term_d: assert property (!role_sel |-> !ctl_d_line_oe_n &&
    ctl_d_line_o == ctl_c_din) else $error("line d not driven from c input");
  a_term_c: assert property (!role_sel && loop_n |->
    ctl_c_dout == ctl_c_line_i) else $error("line c not received");
  a_equip_c: assert property (role_sel |-> ctl_c_dout == ctl_d_line_i &&
    !ctl_c_line_oe_n) else $error("equipment line c or d path wrong");
  a_equip_loop: assert property (role_sel && !loop_n |-> ctl_b_dout == ctl_c_din &&
    ctl_b_line_tx == ctl_b_line_rx && ctl_c_line_o == ctl_b_line_rx) else $error("equip loop wrong");
  a_equip_norm: assert property (role_sel && loop_n |->
    ctl_c_line_o == ctl_c_din) else $error("line c not driven from c input");
endmodule
bind clr_top clr_checker i_chk (.*);

// file: clr_far.sv
// far-side model of the other role driving the cable lines
`timescale 1ns/1ps
module clr_far (
  input wire role_sel,
  input wire [1:0] pat,
  input wire c_o,
  input wire c_oe_n,
  input wire d_o,
  input wire d_oe_n,
  output wire a_rx,
  output wire b_rx,
  output wire c_i,
  output wire d_i
);
  // the far end takes the other role: it sources line c to a terminal, d to equipment
  assign a_rx = pat[0];
  assign b_rx = pat[1];
  // a line nobody drives floats to the pull-up level;
  // the far end sources only one of lines c and d, never both at once
  assign c_i = !c_oe_n ? c_o : (!role_sel ? ~pat[0] : 1'b1);
  assign d_i = !d_oe_n ? d_o : (role_sel ? ~pat[1] : 1'b1);
endmodule

// file: tb.sv
// self-checking bench for the control line router
`timescale 1ns/1ps
module tb;
  logic mclk = 0, rst = 1, role_sel = 0, loop_n = 1, ctl_a_din = 0, ctl_b_din = 0, ctl_c_din = 0;
  logic [1:0] pat = 0;
  logic [4:0] st = 0;
  logic avs_read = 0, avs_write = 0;
  logic [3:0] avs_address = 0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 0, q;
  wire ctl_a_line_rx, ctl_b_line_rx, ctl_c_line_i, ctl_d_line_i, ctl_a_dout, ctl_b_dout;
  wire ctl_c_dout, ctl_a_line_tx, ctl_b_line_tx, ctl_c_line_o, ctl_c_line_oe_n;
  wire ctl_d_line_o, ctl_d_line_oe_n, avs_waitrequest;
  wire [31:0] avs_readdata;
  int mismatches = 0, compares = 0;
  always #2 mclk = ~mclk;
  // the five straps other than role_sel and loop_n come from st so their status bits can be seen moving
  clr_top i_dut (.*, .echo_clk_n(st[0]), .clk_count_sel(st[1]), .clk_invert_n(st[2]),
    .data_invert_n(st[3]), .osc_enable_n(st[4]));
  clr_far i_far (.role_sel(role_sel), .pat(pat), .c_o(ctl_c_line_o), .c_oe_n(ctl_c_line_oe_n),
    .d_o(ctl_d_line_o), .d_oe_n(ctl_d_line_oe_n), .a_rx(ctl_a_line_rx), .b_rx(ctl_b_line_rx),
    .c_i(ctl_c_line_i), .d_i(ctl_d_line_i));
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one avalon word; waits for waitrequest low, bounded
  task av(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
    if (n >= 50)
    begin
      mismatches++;
      wrap_up;
    end
  endtask
  // every role, loopback and input pattern, checked in the cycle it is set
  task t_routes;
    for (int i = 0; i < 128; i++)
    begin
      {role_sel, loop_n, ctl_a_din, ctl_b_din, ctl_c_din, pat} <= i[6:0];
      @(negedge mclk);
      chk(ctl_a_dout, loop_n ? ctl_a_line_rx : ctl_a_din);
      chk(ctl_a_line_tx, loop_n ? ctl_a_din : ctl_a_line_rx);
      chk(ctl_b_dout, loop_n ? ctl_b_line_rx : role_sel ? ctl_c_din : ctl_b_din);
      chk(ctl_b_line_tx, loop_n ? ctl_b_din : role_sel ? ctl_b_line_rx : ctl_c_line_i);
      chk(ctl_c_dout, role_sel ? ctl_d_line_i : loop_n ? ctl_c_line_i : ctl_b_din);
      if (role_sel)
        chk({ctl_d_line_oe_n, ctl_c_line_oe_n, ctl_c_line_o},
          {2'h2, loop_n ? ctl_c_din : ctl_b_line_rx});
      else
        chk({ctl_c_line_oe_n, ctl_d_line_oe_n, ctl_d_line_o}, {2'h2, ctl_c_din});
      @(posedge mclk);
    end
  endtask
  // control register, read-only status, unmapped place, parked unused line
  task t_regs;
    av(0, 4'h4, 0);
    chk(q, 32'h0);
    av(1, 4'h4, 32'h3);
    av(0, 4'h4, 0);
    chk(q, 32'h3);
    chk({ctl_d_line_oe_n, ctl_d_line_o}, 2'h1);
    // a control write without lane 0 enabled is refused
    avs_byteenable <= 4'he;
    av(1, 4'h4, 32'h0);
    avs_byteenable <= 4'hf;
    av(0, 4'h4, 0);
    chk(q, 32'h3);
    av(0, 4'hc, 0);
    chk(q, 32'h0);
    st <= 5'h15;
    loop_n <= 1'b0;
    repeat (8) @(posedge mclk);
    av(1, 4'h0, 32'hffffffff);
    av(0, 4'h0, 0);
    chk({q[9:8], q[6:0]}, {2'h2, 5'h15, 2'h1});
    // settled strap changes: loop up, role and loop together, loop up, straps and loop
    av(0, 4'h8, 0);
    chk(q, 32'h4);
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_routes;
    t_regs;
    wrap_up;
  end
endmodule
